// ==== design/asrp_pkg.sv ====
// Package with constants for the serial result readout port
package asrp_pkg;
    localparam int RESULT_WIDTH = 18;
    localparam logic [17:0] CODE_POS_MAX = 18'h1FFFF;
    localparam logic [17:0] CODE_NEG_MAX = 18'h20000;
    localparam logic [17:0] RESULT_RESET = 18'h00000;
    localparam int CLK_PERIOD_PS = 8000;
    localparam int CONV_TIME_NS = 500;
    localparam int CONV_CYCLES = (CONV_TIME_NS * 1000) / CLK_PERIOD_PS;
    localparam int SYNC_STAGES = 2;
    typedef enum {
        ST_IDLE,
        ST_CONV,
        ST_READY,
        ST_SHIFT
    } asrp_state_e;
endpackage : asrp_pkg

// ==== design/asrp_readout.sv ====
// Serial result readout and conversion-start port
`timescale 1ns/1ps
module asrp_readout #(
    parameter int WIDTH = asrp_pkg::RESULT_WIDTH,
    parameter int CONV_CYCLES = asrp_pkg::CONV_CYCLES
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic convert_start_pin,
    input wire logic serial_in_select_pin,
    input wire logic serialClk,
    input wire logic signed [WIDTH:0] sampleValue,
    output logic serialResultOutO,
    output logic serialResultOutOe,
    output logic conversionBusy
);
    logic cnvS;
    logic sdiS;
    logic sckS;
    logic cnv_r;
    logic sck_r;
    logic sdi_r;
    asrp_pkg::asrp_state_e state_r;
    asrp_pkg::asrp_state_e state_nxt;
    logic chainMode_r;
    logic busyEn_r;
    localparam int CNT_W = $clog2(CONV_CYCLES + 1);
    logic [CNT_W-1:0] convCnt_r;
    logic [WIDTH-1:0] shift_r;
    logic [WIDTH-1:0] shift_nxt;
    logic [5:0] edgeCnt_r;
    logic drive_r;
    logic dout_r;
    logic signed [WIDTH:0] sampleHold_r;
    logic [WIDTH-1:0] clamped;

    asrp_sync uSyncCnv (
        .sys_clk(sys_clk),
        .reset(reset),
        .pinIn(convert_start_pin),
        .pinSync(cnvS)
    );
    asrp_sync uSyncSdi (
        .sys_clk(sys_clk),
        .reset(reset),
        .pinIn(serial_in_select_pin),
        .pinSync(sdiS)
    );
    asrp_sync uSyncSck (
        .sys_clk(sys_clk),
        .reset(reset),
        .pinIn(serialClk),
        .pinSync(sckS)
    );

    wire cnvRise = cnvS && !cnv_r;
    wire cnvFall = !cnvS && cnv_r;
    wire sdiRise = sdiS && !sdi_r;
    wire sdiFall = !sdiS && sdi_r;
    wire sckFall = !sckS && sck_r;
    // Convert edges inside a running conversion do not restart it
    wire convStart = cnvRise && (state_r != asrp_pkg::ST_CONV);
    wire convDone = (state_r == asrp_pkg::ST_CONV) &&
        (convCnt_r == 1);
    // Select mode busy decision at end of conversion
    wire csBusyAtEnd = !cnvS || !sdiS;
    wire busyNow = chainMode_r ? busyEn_r : csBusyAtEnd;
    // Four-wire read select, three-wire uses the convert pin
    wire selLow = !sdiS && !cnvS;
    wire deselect = !chainMode_r && cnvRise;
    wire sdiDeselect = !chainMode_r && cnvS && sdiRise;
    wire lastEdge = (edgeCnt_r == 6'(WIDTH - 1) && !busyEn_r) ||
        (edgeCnt_r == 6'(WIDTH) && busyEn_r);

    // Out-of-range samples clamp to the full-scale codes
    assign clamped = (sampleHold_r > $signed({1'b0, asrp_pkg::CODE_POS_MAX}))
        ? asrp_pkg::CODE_POS_MAX
        : (sampleHold_r < -$signed({1'b0, asrp_pkg::CODE_NEG_MAX}))
        ? asrp_pkg::CODE_NEG_MAX
        : sampleHold_r[WIDTH-1:0];

    assign shift_nxt = {shift_r[WIDTH-2:0],
        chainMode_r ? sdiS : 1'b0};

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            asrp_pkg::ST_IDLE:
                if (cnvRise) state_nxt = asrp_pkg::ST_CONV;
            asrp_pkg::ST_CONV:
                if (convDone) state_nxt = asrp_pkg::ST_READY;
            asrp_pkg::ST_READY:
                if (cnvRise) state_nxt = asrp_pkg::ST_CONV;
                else if (drive_r) state_nxt = asrp_pkg::ST_SHIFT;
            asrp_pkg::ST_SHIFT:
                if (cnvRise) state_nxt = asrp_pkg::ST_CONV;
            default:
                state_nxt = asrp_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            cnv_r <= 1'b0;
            sdi_r <= 1'b0;
            sck_r <= 1'b0;
            state_r <= asrp_pkg::ST_IDLE;
        end else begin
            cnv_r <= cnvS;
            sdi_r <= sdiS;
            sck_r <= sckS;
            state_r <= state_nxt;
        end
    end

    // Mode latched at the convert edge; busy option there in chain mode, at conversion end otherwise
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            chainMode_r <= 1'b0;
            busyEn_r <= 1'b0;
            sampleHold_r <= '0;
        end else if (convStart) begin
            // Serial input taken a cycle early, so a tied convert reads low
            chainMode_r <= !sdi_r;
            busyEn_r <= !sdi_r && sckS;
            sampleHold_r <= sampleValue;
        end else if (convDone && !chainMode_r) begin
            busyEn_r <= busyNow;
        end
    end

    // Internal oscillator timing, no serial clock needed
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            convCnt_r <= '0;
        end else if (convStart) begin
            convCnt_r <= CNT_W'(CONV_CYCLES);
        end else if (convCnt_r != 0) begin
            convCnt_r <= convCnt_r - 1'b1;
        end
    end

    // Shift register and bit counter
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            shift_r <= asrp_pkg::RESULT_RESET;
            edgeCnt_r <= '0;
        end else if (convDone) begin
            shift_r <= clamped;
            edgeCnt_r <= '0;
        end else if (state_r != asrp_pkg::ST_CONV && sckFall && drive_r) begin
            // Busy start bit holds the MSB back by one edge
            if (!(busyEn_r && edgeCnt_r == 0) || chainMode_r && !busyEn_r)
                shift_r <= shift_nxt;
            // Saturate so long chains never wrap into the start-bit slot
            if (edgeCnt_r != 6'h3F)
                edgeCnt_r <= edgeCnt_r + 1'b1;
        end else if (!drive_r && !chainMode_r) begin
            edgeCnt_r <= '0;
        end
    end

    // Output enable and data, set by convert and select events and shifted on falling serial edges
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            drive_r <= 1'b0;
            dout_r <= 1'b0;
        end else if (cnvRise && !sdi_r) begin
            drive_r <= 1'b1;
            dout_r <= 1'b0;
        end else if (cnvRise || deselect) begin
            drive_r <= 1'b0;
        end else if (state_r == asrp_pkg::ST_CONV) begin
            if (convDone && chainMode_r) begin
                drive_r <= 1'b1;
                dout_r <= busyEn_r ? 1'b1 : clamped[WIDTH-1];
            end else if (convDone && busyNow) begin
                drive_r <= 1'b1;
                dout_r <= 1'b0;
            end else if (!convDone && selLow && !chainMode_r) begin
                drive_r <= 1'b1;
                dout_r <= 1'b0;
            end else if (!convDone && !chainMode_r) begin
                drive_r <= 1'b0;
            end
        end else if (sdiDeselect) begin
            drive_r <= 1'b0;
        end else if (selLow && !chainMode_r &&
                state_r != asrp_pkg::ST_IDLE) begin
            drive_r <= 1'b1;
            dout_r <= 1'b0;
        end else if (!chainMode_r && !busyEn_r && !drive_r &&
                (cnvFall || sdiFall) && edgeCnt_r == 0) begin
            drive_r <= 1'b1;
            dout_r <= shift_r[WIDTH-1];
        end else if (sckFall && drive_r) begin
            if (!chainMode_r && lastEdge) begin
                drive_r <= 1'b0;
            end else if (busyEn_r && edgeCnt_r == 0) begin
                dout_r <= shift_r[WIDTH-1];
            end else begin
                dout_r <= shift_nxt[WIDTH-1];
            end
        end
    end

    assign serialResultOutO = dout_r;
    assign serialResultOutOe = drive_r;
    assign conversionBusy = (state_r == asrp_pkg::ST_CONV);

    property p_mode_select;
        @(posedge sys_clk) disable iff (reset)
        convStart |=> chainMode_r == !$past(sdi_r);
    endproperty
    a_mode_select: assert property (p_mode_select)
        else $error("mode not taken from serial input");

    property p_chain_busy;
        @(posedge sys_clk) disable iff (reset)
        convStart && !sdi_r |=> busyEn_r == $past(sckS);
    endproperty
    a_chain_busy: assert property (p_chain_busy)
        else $error("chain busy option wrong");

    property p_float_on_start;
        @(posedge sys_clk) disable iff (reset)
        cnvRise && sdi_r |=> !drive_r;
    endproperty
    a_float_on_start: assert property (p_float_on_start)
        else $error("output not floated at conversion start");

    sequence s_conv_start;
        cnvRise && state_r != asrp_pkg::ST_CONV;
    endsequence
    property p_conv_runs;
        @(posedge sys_clk) disable iff (reset)
        s_conv_start |=> (state_r == asrp_pkg::ST_CONV)[*8];
    endproperty
    a_conv_runs: assert property (p_conv_runs)
        else $error("conversion cut short");

    property p_result_load;
        @(posedge sys_clk) disable iff (reset)
        convDone |=> shift_r == $past(clamped);
    endproperty
    a_result_load: assert property (p_result_load)
        else $error("result not loaded");

    property p_busy_low;
        @(posedge sys_clk) disable iff (reset)
        convDone && !chainMode_r && busyNow && !cnvRise
            |=> drive_r && !dout_r;
    endproperty
    a_busy_low: assert property (p_busy_low)
        else $error("busy low not driven");

    property p_clamp;
        @(posedge sys_clk) disable iff (reset)
        sampleHold_r > $signed({1'b0, asrp_pkg::CODE_POS_MAX})
            |-> clamped == asrp_pkg::CODE_POS_MAX;
    endproperty
    a_clamp: assert property (p_clamp)
        else $error("overrange not clamped");

    property p_sel_low;
        @(posedge sys_clk) disable iff (reset)
        state_r == asrp_pkg::ST_CONV && selLow && !chainMode_r
            && !convDone && !cnvRise |=> drive_r && !dout_r;
    endproperty
    a_sel_low: assert property (p_sel_low)
        else $error("output not low when selected");

    property p_sel_low_idle;
        @(posedge sys_clk) disable iff (reset)
        selLow && !chainMode_r && state_r != asrp_pkg::ST_IDLE
            && state_r != asrp_pkg::ST_CONV |=> drive_r && !dout_r;
    endproperty
    a_sel_low_idle: assert property (p_sel_low_idle)
        else $error("output not low when both selects low");

    property p_stable_data;
        @(posedge sys_clk) disable iff (reset)
        !sckFall && !cnvRise && !convDone && !cnvFall && !sdiFall
            && state_r != asrp_pkg::ST_CONV |=> $stable(dout_r);
    endproperty
    a_stable_data: assert property (p_stable_data)
        else $error("data changed off a falling edge");
endmodule : asrp_readout

// ==== design/asrp_sync.sv ====
// Two flip-flop synchroniser for one pin
`timescale 1ns/1ps
module asrp_sync (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic pinIn,
    output logic pinSync
);
    logic meta_r;

    // First stage is read only by the second
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            meta_r <= 1'b0;
            pinSync <= 1'b0;
        end else begin
            meta_r <= pinIn;
            pinSync <= meta_r;
        end
    end
endmodule : asrp_sync

// ==== verif/asrp_host_model.sv ====
// Host controller model that drives the readout port pins
`timescale 1ns/1ps
module asrp_host_model #(
    parameter int HALF = 10
) (
    input wire logic sys_clk,
    input wire logic dataLine,
    output logic convPin,
    output logic selPin,
    output logic sck
);
    initial begin
        convPin = 1'b0;
        selPin = 1'b1;
        sck = 1'b0;
    end

    task automatic idle(input int n);
        repeat (n) @(posedge sys_clk);
    endtask : idle

    // Levels change only after a clock edge; one device on the line
    task automatic pins(input logic c, input logic s, input logic k);
        @(posedge sys_clk);
        convPin <= c;
        selPin <= s;
        sck <= k;
    endtask : pins

    // Clock stands still outside frames; bit taken late in the low half
    task automatic shift(input int n, input bit feed, input logic [17:0] w,
                         output logic [35:0] got);
        logic [17:0] sh;
        sh = w;
        got = '0;
        for (int i = 0; i < n; i++) begin
            got = {got[34:0], dataLine};
            @(posedge sys_clk);
            sck <= 1'b1;
            if (feed) begin
                selPin <= sh[17];
            end
            sh = sh << 1;
            idle(HALF);
            sck <= 1'b0;
            idle(HALF);
        end
    endtask : shift
endmodule : asrp_host_model

// ==== verif/test_asrp_readout.sv ====
// Self-checking bench for the serial result readout port
`timescale 1ns/1ps
module test_asrp_readout;
    localparam int CONV_P = 8;
    localparam int SETTLE = 6;
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    logic signed [18:0] sampleValue = '0;
    logic outO;
    logic outOe;
    logic busy;
    wire logic convPin;
    wire logic selPin;
    wire logic sck;
    wire logic dataLine;
    int fails = 0;
    int n_compared = 0;
    int seed = 46;
    logic [35:0] got;
    logic [17:0] word;
    logic signed [18:0] corners [4] = '{19'sh20005, 19'sh5FFF0,
                                       19'sh7FFFF, 19'sh1FFFF};

    always #4 sys_clk = ~sys_clk;
    // Pull-up so a floated line reads high
    assign dataLine = outOe ? outO : 1'b1;

    asrp_readout #(.CONV_CYCLES(CONV_P)) asrp_readout_inst (
        .sys_clk(sys_clk),
        .reset(reset),
        .convert_start_pin(convPin),
        .serial_in_select_pin(selPin),
        .serialClk(sck),
        .sampleValue(sampleValue),
        .serialResultOutO(outO),
        .serialResultOutOe(outOe),
        .conversionBusy(busy)
    );

    asrp_host_model asrp_host_model_inst (
        .sys_clk(sys_clk),
        .dataLine(dataLine),
        .convPin(convPin),
        .selPin(selPin),
        .sck(sck)
    );

    function automatic logic [17:0] expCode(input logic signed [18:0] v);
        if (v > 19'sh1FFFF) return asrp_pkg::CODE_POS_MAX;
        if (v < 19'sh60000) return asrp_pkg::CODE_NEG_MAX;
        return v[17:0];
    endfunction : expCode

    task automatic check(input logic [35:0] act, input logic [35:0] exp);
        n_compared++;
        if (act !== exp) begin
            fails++;
            $display("BAD t=%0t act=%h exp=%h", $time, act, exp);
        end
    endtask : check

    task automatic tally_and_finish;
        if (fails == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : tally_and_finish

    // Corner codes first, then random samples
    task automatic newSample(input int k);
        @(posedge sys_clk);
        sampleValue <= (k < 4) ? corners[k] : 19'($random(seed));
    endtask : newSample

    initial begin
        #100us;
        fails++;
        tally_and_finish();
    end

    initial begin
        repeat (12) @(posedge sys_clk);
        check(36'(outOe), 36'h0);
        reset <= 1'b0;
        asrp_host_model_inst.idle(4);
        for (int k = 0; k < 6; k++) begin
            newSample(k);
            asrp_host_model_inst.pins(1'b1, 1'b1, 1'b0);
            asrp_host_model_inst.idle(SETTLE);
            check(36'(outOe), 36'h0);
            check(36'(busy), 36'h1);
            asrp_host_model_inst.idle(CONV_P + SETTLE);
            check(36'(busy), 36'h0);
            asrp_host_model_inst.pins(1'b0, 1'b1, 1'b0);
            asrp_host_model_inst.idle(SETTLE);
            check(36'(outOe), 36'h1);
            asrp_host_model_inst.shift(18, 1'b0, '0, got);
            check(got, 36'(expCode(sampleValue)));
            asrp_host_model_inst.idle(SETTLE);
            check(36'(outOe), 36'h0);
        end
        newSample(9);
        asrp_host_model_inst.pins(1'b1, 1'b1, 1'b0);
        asrp_host_model_inst.idle(3);
        asrp_host_model_inst.pins(1'b0, 1'b1, 1'b0);
        asrp_host_model_inst.idle(2);
        check(36'(outOe), 36'h0);
        asrp_host_model_inst.idle(CONV_P + SETTLE);
        check(36'({outOe, outO}), 36'h2);
        asrp_host_model_inst.shift(19, 1'b0, '0, got);
        check(got, 36'({1'b0, expCode(sampleValue)}));
        asrp_host_model_inst.idle(SETTLE);
        check(36'(outOe), 36'h0);
        newSample(10);
        asrp_host_model_inst.pins(1'b1, 1'b1, 1'b0);
        asrp_host_model_inst.idle(CONV_P + 2 * SETTLE);
        check(36'(outOe), 36'h0);
        asrp_host_model_inst.pins(1'b1, 1'b0, 1'b0);
        asrp_host_model_inst.idle(SETTLE);
        asrp_host_model_inst.shift(18, 1'b0, '0, got);
        check(got, 36'(expCode(sampleValue)));
        asrp_host_model_inst.idle(SETTLE);
        check(36'(outOe), 36'h0);
        asrp_host_model_inst.pins(1'b0, 1'b1, 1'b0);
        asrp_host_model_inst.pins(1'b1, 1'b1, 1'b0);
        asrp_host_model_inst.idle(CONV_P + 2 * SETTLE);
        asrp_host_model_inst.pins(1'b1, 1'b0, 1'b0);
        asrp_host_model_inst.shift(5, 1'b0, '0, got);
        asrp_host_model_inst.pins(1'b1, 1'b1, 1'b0);
        asrp_host_model_inst.idle(SETTLE);
        check(36'(outOe), 36'h0);
        asrp_host_model_inst.pins(1'b0, 1'b0, 1'b0);
        asrp_host_model_inst.idle(SETTLE);
        check(36'({outOe, outO}), 36'h2);
        newSample(11);
        word = 18'($random(seed));
        asrp_host_model_inst.pins(1'b1, 1'b0, 1'b0);
        asrp_host_model_inst.idle(CONV_P + 2 * SETTLE);
        check(36'(outOe), 36'h1);
        asrp_host_model_inst.shift(36, 1'b1, word, got);
        check(got, {expCode(sampleValue), word});
        // Chain mode again, serial clock high at the convert edge
        newSample(12);
        asrp_host_model_inst.pins(1'b0, 1'b0, 1'b1);
        asrp_host_model_inst.pins(1'b1, 1'b0, 1'b1);
        asrp_host_model_inst.idle(2);
        asrp_host_model_inst.pins(1'b1, 1'b0, 1'b0);
        asrp_host_model_inst.idle(CONV_P + 2 * SETTLE);
        check(36'({outOe, outO}), 36'h3);
        asrp_host_model_inst.shift(19, 1'b0, '0, got);
        check(got, 36'({1'b1, expCode(sampleValue)}));
        tally_and_finish();
    end
endmodule : test_asrp_readout
